/* design/prx_top.sv */
// Receive status and reset block of the medium attachment layer.
// Assumes an AHB-Lite master, a symbol slicer feeding raw pair symbols on the link clock,
// and coding-sublayer logic that reports descrambler lock.
// Operation
// - Each received four-pair vector goes to the coding sublayer as one transfer, pairs A to D.
// - A vector is produced on each rising edge of the recovered link clock, in step with the line; here a link clock pulse wholly within ce_i low is lost.
// - The local receiver health goes to coding, PHY control and link monitor logic.
// - Local health is updated continuously, stays OK while reception is good, else NOT_OK.
// - Local health is judged from symbol errors seen on the received stream.
// - The attachment reset indication, when true, forces the coding-sublayer reset on.
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
module prx_top (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic rx_clk_i,
    input wire logic [prx_pkg::SYM_W-1:0] pair_a_i,
    input wire logic [prx_pkg::SYM_W-1:0] pair_b_i,
    input wire logic [prx_pkg::SYM_W-1:0] pair_c_i,
    input wire logic [prx_pkg::SYM_W-1:0] pair_d_i,
    input wire logic scr_status_i,
    input wire logic hsel_i,
    input wire logic [prx_pkg::ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [prx_pkg::SYM_W-1:0] pair_a_o,
    output logic [prx_pkg::SYM_W-1:0] pair_b_o,
    output logic [prx_pkg::SYM_W-1:0] pair_c_o,
    output logic [prx_pkg::SYM_W-1:0] pair_d_o,
    output logic four_dim_symbol_valid_o,
    output logic loc_rcvr_status_o,
    output logic attachment_reset_indication_o,
    output logic irq_o
);
    import prx_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Every data line from the link side passes two flops and only the second stage is read; the link clock passes three, its edge found from stages two and three.
    logic [2:0] rclk_sync;
    logic [1:0] scr_sync;
    logic [VEC_W-1:0] sym_s1;
    logic [VEC_W-1:0] sym_s2;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rclk_sync <= '0;
            scr_sync <= '0;
            sym_s1 <= '0;
            sym_s2 <= '0;
        end else if (ce_i) begin
            rclk_sync <= {rclk_sync[1:0], rx_clk_i};
            scr_sync <= {scr_sync[0], scr_status_i};
            sym_s1 <= {pair_a_i, pair_b_i, pair_c_i, pair_d_i};
            sym_s2 <= sym_s1;
        end
    end
    logic rclk_rise;
    assign rclk_rise = rclk_sync[1] & ~rclk_sync[2];
    logic scr_ok;
    assign scr_ok = scr_sync[1];

    // Symbols outside the legal range count as decision errors.
    function automatic logic sym_bad(input logic [SYM_W-1:0] s);
        return ($signed(s) > $signed(SYM_MAX)) || ($signed(s) < $signed(SYM_MIN));
    endfunction

    // ------------------------------------------------------------
    // Register bus state
    // ------------------------------------------------------------
    logic [1:0] ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [ERR_CNT_W-1:0] err_limit;
    logic ph_wr;
    logic [ADDR_W-1:0] ph_addr;
    logic [1:0] next_ctrl;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [ERR_CNT_W-1:0] next_err_limit;
    logic next_ph_wr;
    logic [ADDR_W-1:0] next_ph_addr;
    logic [31:0] next_hrdata;

    // ------------------------------------------------------------
    // Receive path and health state
    // ------------------------------------------------------------
    logic [VEC_W-1:0] vec_q;
    logic vec_valid;
    logic loc_ok;
    logic scr_ok_d;
    logic [ERR_CNT_W-1:0] err_cnt;
    logic [GOOD_CNT_W-1:0] good_cnt;
    logic rst_ind;
    logic [VEC_W-1:0] next_vec_q;
    logic next_vec_valid;
    logic next_loc_ok;
    logic [ERR_CNT_W-1:0] next_err_cnt;
    logic [GOOD_CNT_W-1:0] next_good_cnt;
    logic next_rst_ind;
    logic [IRQ_W-1:0] events;
    logic [VEC_W-1:0] last_vec;
    logic vec_bad;

    // Capture a whole vector at each rising recovered clock edge so the four pairs stay aligned.
    always_comb begin
        next_vec_q = vec_q;
        next_vec_valid = 1'b0;
        next_err_cnt = err_cnt;
        next_good_cnt = good_cnt;
        next_loc_ok = loc_ok;
        vec_bad = 1'b0;
        if (rclk_rise) begin
            next_vec_q = sym_s2;
            next_vec_valid = 1'b1;
            vec_bad = sym_bad(sym_s2[4*SYM_W-1:3*SYM_W]) | sym_bad(sym_s2[3*SYM_W-1:2*SYM_W])
                | sym_bad(sym_s2[2*SYM_W-1:SYM_W]) | sym_bad(sym_s2[SYM_W-1:0]);
            // Errors drop health at the limit; a clean run restores it.
            if (vec_bad) begin
                next_good_cnt = '0;
                if (err_cnt != err_limit) begin
                    next_err_cnt = err_cnt + 1'b1;
                end
            end else if (good_cnt != GOOD_CNT_W'(GOOD_CYC)) begin
                next_good_cnt = good_cnt + 1'b1;
            end else begin
                next_err_cnt = '0;
            end
        end
        // Health is re-judged every cycle: it drops once errors reach the limit and only
        // returns after a full clean run, so one stray bad symbol cannot flap it.
        if (ctrl[CTRL_FORCE_BAD_BIT] || rst_ind || (next_err_cnt == err_limit)) begin
            next_loc_ok = 1'b0;
        end else if (next_good_cnt == GOOD_CNT_W'(GOOD_CYC)) begin
            next_loc_ok = 1'b1;
        end
        // The reset indication follows the management reset bit as a level.
        next_rst_ind = ctrl[CTRL_RESET_BIT];
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            vec_q <= '0;
            vec_valid <= 1'b0;
            err_cnt <= '0;
            good_cnt <= '0;
            loc_ok <= 1'b0;
            rst_ind <= 1'b1;
            scr_ok_d <= 1'b0;
        end else if (ce_i) begin
            vec_q <= next_vec_q;
            vec_valid <= next_vec_valid;
            err_cnt <= next_err_cnt;
            good_cnt <= next_good_cnt;
            loc_ok <= next_loc_ok;
            rst_ind <= next_rst_ind;
            scr_ok_d <= scr_ok;
        end
    end

    // Last vector is kept readable by software.
    prx_vec_reg u_vec_reg (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .wr_i(next_vec_valid),
        .wdata_i(next_vec_q),
        .rdata_o(last_vec)
    );

    // Events feeding sticky interrupt bits.
    always_comb begin
        events = '0;
        events[IRQ_VEC_BIT] = vec_valid;
        events[IRQ_LOC_CHG_BIT] = next_loc_ok ^ loc_ok;
        events[IRQ_SCR_CHG_BIT] = scr_ok ^ scr_ok_d;
        events[IRQ_ERR_BIT] = vec_bad;
    end

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Zero wait states; a write lands in its data phase, a read returns from the next edge.
    always_comb begin
        next_ctrl = ctrl;
        next_irq_mask = irq_mask;
        next_err_limit = err_limit;
        next_irq_stat = irq_stat;
        next_ph_wr = 1'b0;
        next_ph_addr = ph_addr;
        next_hrdata = '0;
        if (ph_wr) begin
            unique case (ph_addr)
                OFS_CTRL: next_ctrl = hwdata_i[1:0];
                OFS_IRQ_STAT: next_irq_stat = irq_stat & ~hwdata_i[IRQ_W-1:0];
                OFS_IRQ_MASK: next_irq_mask = hwdata_i[IRQ_W-1:0];
                OFS_ERR_LIMIT: next_err_limit = hwdata_i[ERR_CNT_W-1:0];
                default: ;
            endcase
        end
        // A set in the same cycle as a write-one clear wins.
        next_irq_stat = next_irq_stat | events;
        if (hsel_i && hready_i && htrans_i[1]) begin
            next_ph_wr = hwrite_i;
            next_ph_addr = haddr_i;
            if (!hwrite_i) begin
                unique case (haddr_i)
                    OFS_CTRL: next_hrdata = {30'h0, ctrl};
                    OFS_STATUS: next_hrdata = {29'h0, rst_ind, scr_ok, loc_ok};
                    OFS_IRQ_STAT: next_hrdata = {28'h0, irq_stat};
                    OFS_IRQ_MASK: next_hrdata = {28'h0, irq_mask};
                    OFS_ERR_LIMIT: next_hrdata = {24'h0, err_limit};
                    OFS_LAST_SYM: next_hrdata = last_vec;
                    default: next_hrdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl <= CTRL_RST;
            irq_stat <= '0;
            irq_mask <= IRQ_MASK_RST;
            err_limit <= ERR_LIMIT_RST;
            ph_wr <= 1'b0;
            ph_addr <= '0;
            hrdata_o <= '0;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            ctrl <= next_ctrl;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            err_limit <= next_err_limit;
            ph_wr <= next_ph_wr;
            ph_addr <= next_ph_addr;
            hrdata_o <= next_hrdata;
            irq_o <= |(next_irq_stat & next_irq_mask);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end
    assign pair_a_o = vec_q[4*SYM_W-1:3*SYM_W];
    assign pair_b_o = vec_q[3*SYM_W-1:2*SYM_W];
    assign pair_c_o = vec_q[2*SYM_W-1:SYM_W];
    assign pair_d_o = vec_q[SYM_W-1:0];
    assign four_dim_symbol_valid_o = vec_valid;
    assign loc_rcvr_status_o = loc_ok;
    assign attachment_reset_indication_o = rst_ind;
endmodule

/* design/prx_pkg.sv */
// Package for the attachment-layer receive status and reset block.
// Assumes one 100 MHz system clock; the recovered link clock is sampled as a plain input.
package prx_pkg;
    // ------------------------------------------------------------
    // Symbol and bus geometry
    // ------------------------------------------------------------
    localparam int SYM_W = 8;
    localparam int NUM_PAIRS = 4;
    localparam int VEC_W = SYM_W * NUM_PAIRS;
    localparam int ADDR_W = 8;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_ERR_LIMIT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_LAST_SYM = 8'h14;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_FORCE_BAD_BIT = 1;
    localparam int ST_LOC_OK_BIT = 0;
    localparam int ST_SCR_OK_BIT = 1;
    localparam int ST_RESET_BIT = 2;
    localparam int IRQ_W = 4;
    localparam int IRQ_VEC_BIT = 0;
    localparam int IRQ_LOC_CHG_BIT = 1;
    localparam int IRQ_SCR_CHG_BIT = 2;
    localparam int IRQ_ERR_BIT = 3;
    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    localparam int ERR_CNT_W = 8;
    localparam logic [ERR_CNT_W-1:0] ERR_LIMIT_RST = 8'h04;
    localparam int GOOD_NS = 640;
    localparam int CLK_MHZ = 100;
    localparam int GOOD_CYC = (GOOD_NS * CLK_MHZ) / 1000;
    localparam int GOOD_CNT_W = 8;
    localparam logic [SYM_W-1:0] SYM_MAX = 8'h7f;
    localparam logic [SYM_W-1:0] SYM_MIN = 8'h81;
endpackage

/* design/prx_vec_reg.sv */
// Holds the last received four-pair symbol vector as one register word.
// Assumes writes come from the capture logic on the same clock.
`timescale 1ns/10ps
module prx_vec_reg (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic [prx_pkg::VEC_W-1:0] wdata_i,
    output logic [prx_pkg::VEC_W-1:0] rdata_o
);
    import prx_pkg::*;
    logic [VEC_W-1:0] store;
    logic [VEC_W-1:0] next_store;

    // Next value: the word is replaced only on a write.
    always_comb begin
        next_store = store;
        if (wr_i) begin
            next_store = wdata_i;
        end
    end

    // Register, frozen while the clock enable is low.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            store <= '0;
        end else if (ce_i) begin
            store <= next_store;
        end
    end

    assign rdata_o = store;
endmodule

/* test/prx_far_model.sv */
// Far-side model: symbol slicer and coding-sublayer lock report feeding the block.
// Assumes the bench calls its tasks; its reset and remote-health logic run on the system clock.
`timescale 1ns/10ps
module prx_far_model (
    input wire logic clk_i,
    input wire logic loc_ok_i,
    input wire logic rst_ind_i,
    output logic rx_clk_o,
    output logic [prx_pkg::SYM_W-1:0] pair_a_o,
    output logic [prx_pkg::SYM_W-1:0] pair_b_o,
    output logic [prx_pkg::SYM_W-1:0] pair_c_o,
    output logic [prx_pkg::SYM_W-1:0] pair_d_o,
    output logic scr_status_o,
    output logic pcs_reset_o,
    output logic [3:0] func_run_o,
    output logic rem_ok_o
);
    import prx_pkg::*;
    logic pwr_on = 1'b1;
    logic rem_decoded = 1'b0;
    // Coding-sublayer reset holds at power-on and while the attachment asks for it.
    assign pcs_reset_o = pwr_on | rst_ind_i;
    // Four operating functions, each held in its reset branch while reset holds.
    always @(posedge clk_i) begin
        pwr_on <= 1'b0;
        if (pcs_reset_o) begin
            func_run_o <= 4'h0;
        end else begin
            func_run_o <= 4'hf;
        end
    end
    // Remote health is held NOT_OK until local health is OK, then follows the decoded value.
    always @(posedge clk_i) begin
        if (pcs_reset_o || loc_ok_i !== 1'b1) begin
            rem_ok_o <= 1'b0;
        end else begin
            rem_ok_o <= rem_decoded;
        end
    end
    // Value decoded from the partner's encoding of its own receiver health.
    task automatic set_remote(input logic ok);
        rem_decoded = ok;
    endtask
    // The link clock stands still low between vectors.
    initial begin
        rx_clk_o = 1'b0;
        {pair_a_o, pair_b_o, pair_c_o, pair_d_o} = 32'ha5a5a5a5;
        scr_status_o = 1'b0;
    end
    // One vector per 160 ns link period; after the hold time the pairs show the inverse.
    // Edges are kept 2 ns off the system clock so sampling never races the model.
    task automatic send(input logic [VEC_W-1:0] v);
        #2;
        {pair_a_o, pair_b_o, pair_c_o, pair_d_o} = v;
        #40;
        rx_clk_o = 1'b1;
        #80;
        rx_clk_o = 1'b0;
        #20;
        {pair_a_o, pair_b_o, pair_c_o, pair_d_o} = ~v;
        #18;
    endtask
    // Lock status is a plain level, one meaning synchronized.
    task automatic set_lock(input logic ok);
        scr_status_o = ok;
    endtask
endmodule

/* test/prx_top_assertions.sv */
// Checker for the receive status block; sees only the top module's ports.
// Assumes a single clock domain with synchronous active-high reset.
`timescale 1ns/10ps
module prx_top_assertions (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic rx_clk_i,
    input wire logic [prx_pkg::SYM_W-1:0] pair_a_o,
    input wire logic [prx_pkg::SYM_W-1:0] pair_b_o,
    input wire logic [prx_pkg::SYM_W-1:0] pair_c_o,
    input wire logic [prx_pkg::SYM_W-1:0] pair_d_o,
    input wire logic four_dim_symbol_valid_o,
    input wire logic loc_rcvr_status_o,
    input wire logic attachment_reset_indication_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o
);
    import prx_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    // A low clock enable freezes the block, so every property attempt is dropped while it is low.
    default disable iff (sys_rst_i || !ce_i);
    // Two sync flops plus capture bound the vector latency.
    sequence s_vec_out;
        ##[2:7] four_dim_symbol_valid_o;
    endsequence
    sequence s_fresh;
        (attachment_reset_indication_o && !loc_rcvr_status_o) [*4];
    endsequence
    property p_vec_lat;
        $rose(rx_clk_i) |-> s_vec_out;
    endproperty
    property p_vec_pulse;
        four_dim_symbol_valid_o |=> !four_dim_symbol_valid_o;
    endproperty
    property p_vec_hold;
        !four_dim_symbol_valid_o |-> $stable({pair_a_o, pair_b_o, pair_c_o, pair_d_o});
    endproperty
    property p_loc_good;
        $rose(loc_rcvr_status_o) |-> pair_a_o != SYM_MAX + 8'h01 && pair_b_o != 8'h80
            && pair_c_o != 8'h80 && pair_d_o != 8'h80;
    endproperty
    property p_rst_ind;
        $fell(sys_rst_i) |-> s_fresh;
    endproperty
    property p_loc_start;
        $fell(sys_rst_i) |-> !loc_rcvr_status_o [*8];
    endproperty
    property p_ready;
        hreadyout_o;
    endproperty
    property p_resp;
        !hresp_o;
    endproperty
    a_vec_lat: assert property (p_vec_lat) else $error("no vector after link edge");
    a_vec_pulse: assert property (p_vec_pulse) else $error("valid longer than one cycle");
    a_vec_hold: assert property (p_vec_hold) else $error("pairs moved without valid");
    a_loc_good: assert property (p_loc_good) else $error("health rose on a bad vector");
    a_rst_ind: assert property (p_rst_ind) else $error("reset indication not true");
    a_loc_start: assert property (p_loc_start) else $error("health ok too soon");
    a_ready: assert property (p_ready) else $error("bus stalled");
    a_resp: assert property (p_resp) else $error("bus error response");
endmodule
bind prx_top prx_top_assertions u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .rx_clk_i(rx_clk_i), .pair_a_o(pair_a_o), .pair_b_o(pair_b_o), .pair_c_o(pair_c_o),
    .pair_d_o(pair_d_o), .four_dim_symbol_valid_o(four_dim_symbol_valid_o),
    .loc_rcvr_status_o(loc_rcvr_status_o),
    .attachment_reset_indication_o(attachment_reset_indication_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));

/* test/tb.sv */
// Self-checking bench for the receive status block.
// Assumes the far-side model and the bound checker; clock and enable come from here.
`timescale 1ns/10ps
module tb;
    import prx_pkg::*;
    logic clk_i, sys_rst_i, hsel_i, hwrite_i, rx_clk, scr, rdy, resp, valid, loc, rst_ind, irq;
    logic [ADDR_W-1:0] haddr_i;
    logic [1:0] htrans_i;
    logic [31:0] hwdata_i, hrdata;
    logic [SYM_W-1:0] pa, pb, pc, pd, qa, qb, qc, qd;
    logic ce, pcs_rst, rem_ok;
    logic [2:0] hsize;
    logic [3:0] func_run;
    int n_mismatch = 0;
    int total_checks = 0;
    int n_valid = 0;
    prx_far_model far (.clk_i(clk_i), .loc_ok_i(loc), .rst_ind_i(rst_ind), .rx_clk_o(rx_clk),
        .pair_a_o(pa), .pair_b_o(pb), .pair_c_o(pc), .pair_d_o(pd), .scr_status_o(scr),
        .pcs_reset_o(pcs_rst), .func_run_o(func_run), .rem_ok_o(rem_ok));
    prx_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .rx_clk_i(rx_clk),
        .pair_a_i(pa), .pair_b_i(pb), .pair_c_i(pc), .pair_d_i(pd), .scr_status_i(scr),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(hsize), .hwdata_i(hwdata_i), .hready_i(rdy), .hrdata_o(hrdata),
        .hreadyout_o(rdy), .hresp_o(resp), .pair_a_o(qa), .pair_b_o(qb), .pair_c_o(qc),
        .pair_d_o(qd), .four_dim_symbol_valid_o(valid), .loc_rcvr_status_o(loc),
        .attachment_reset_indication_o(rst_ind), .irq_o(irq));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Counts valid pulses so each vector can be checked to arrive exactly once.
    always @(posedge clk_i) begin
        if (valid === 1'b1) begin
            n_valid <= n_valid + 1;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One AHB-Lite single transfer; each phase is held until hready is sampled high.
    task automatic ahb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= wr;
        hsize <= 3'h2;
        do @(posedge clk_i); while (rdy !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_i); while (rdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] v;
        ahb(1'b1, a, d, v);
        repeat (2) @(posedge clk_i);
    endtask
    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] v;
        ahb(1'b0, a, 32'h0, v);
        chk(what, e, v);
    endtask
    // Reset indication follows the control bit; unmapped space reads zero.
    task automatic t_reset();
        chk("reset pin", 32'h1, 32'(rst_ind));
        chk("pcs reset at power-on", 32'h1, 32'(pcs_rst));
        rdchk("status", OFS_STATUS, 32'h4);
        chk("okay response", 32'h0, 32'(resp));
        wr(OFS_CTRL, 32'h0);
        @(posedge clk_i);
        chk("reset pin off", 32'h0, 32'(rst_ind));
        chk("pcs reset off", 32'h0, 32'(pcs_rst));
        chk("functions running", 32'hf, 32'(func_run));
        wr(OFS_CTRL, 32'h1);
        @(posedge clk_i);
        chk("reset pin on", 32'h1, 32'(rst_ind));
        chk("pcs reset on", 32'h1, 32'(pcs_rst));
        chk("functions in reset", 32'h0, 32'(func_run));
        wr(OFS_CTRL, 32'h0);
        wr(8'h1c, 32'hffffffff);
        rdchk("unmapped", 8'h1c, 32'h0);
        $display("test reset done");
    endtask
    // One vector arrives whole; its event raises, masks and clears the interrupt.
    task automatic t_vector();
        int seen;
        seen = n_valid;
        far.send(32'h017f81fe);
        chk("pairs", 32'h017f81fe, {qa, qb, qc, qd});
        chk("valid pulses", 32'(seen + 1), 32'(n_valid));
        rdchk("last vector", OFS_LAST_SYM, 32'h017f81fe);
        rdchk("irq status", OFS_IRQ_STAT, 32'h1);
        chk("irq masked", 32'h0, 32'(irq));
        wr(OFS_IRQ_MASK, 32'h1);
        chk("irq raised", 32'h1, 32'(irq));
        wr(OFS_IRQ_STAT, 32'h1);
        chk("irq cleared", 32'h0, 32'(irq));
        wr(OFS_IRQ_MASK, 32'h0);
        $display("test vector done");
    endtask
    // Lock report, health rising after good vectors and falling at the error limit.
    task automatic t_health();
        far.set_lock(1'b1);
        repeat (5) @(posedge clk_i);
        rdchk("lock seen", OFS_STATUS, 32'h2);
        far.set_remote(1'b1);
        chk("remote held", 32'h0, 32'(rem_ok));
        repeat (64) far.send(32'h10203040);
        chk("health ok", 32'h1, 32'(loc));
        chk("remote ok", 32'h1, 32'(rem_ok));
        repeat (3) far.send(32'h11228044);
        chk("health below limit", 32'h1, 32'(loc));
        far.send(32'h11228044);
        chk("health bad", 32'h0, 32'(loc));
        chk("remote dropped", 32'h0, 32'(rem_ok));
        rdchk("irq events", OFS_IRQ_STAT, 32'hf);
        $display("test health done");
    endtask
    // A low clock enable freezes the block: a vector sent meanwhile is lost, not queued.
    task automatic t_freeze();
        int seen;
        seen = n_valid;
        ce <= 1'b0;
        @(posedge clk_i);
        far.send(32'h05060708);
        chk("frozen pairs", 32'h11228044, {qa, qb, qc, qd});
        chk("frozen valid", 32'(seen), 32'(n_valid));
        @(posedge clk_i);
        ce <= 1'b1;
        far.send(32'h05060708);
        chk("pairs after freeze", 32'h05060708, {qa, qb, qc, qd});
        chk("one valid after freeze", 32'(seen + 1), 32'(n_valid));
        $display("test freeze done");
    endtask
    initial begin
        sys_rst_i = 1'b1;
        hsel_i = 1'b0;
        htrans_i = 2'h0;
        haddr_i = 8'h00;
        hwrite_i = 1'b0;
        hwdata_i = 32'h0;
        ce = 1'b1;
        hsize = 3'h2;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_vector();
        t_health();
        t_freeze();
        wrap_up();
    end
    // Tests need about 12 us; anything far beyond is a hang.
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
endmodule
